// >>> design/bpp_top.sv
`timescale 1ns/1ps
`include "bpp_defines.svh"
module bpp_top #(
	parameter int CW = `BPP_CNT_W,
	parameter int OC_DET = `BPP_OC_DET_US * `BPP_CLK_MHZ,
	parameter int OC_REL = `BPP_OC_REL_US * `BPP_CLK_MHZ,
	parameter int OD_DET = `BPP_OD_DET_US * `BPP_CLK_MHZ,
	parameter int OD_REL = `BPP_OD_REL_US * `BPP_CLK_MHZ,
	parameter int OI_DET = `BPP_OI_DET_US * `BPP_CLK_MHZ,
	parameter int OI_REL = `BPP_OI_REL_US * `BPP_CLK_MHZ,
	parameter int XC_DET = `BPP_XC_DET_US * `BPP_CLK_MHZ,
	parameter int XC_REL = `BPP_XC_REL_US * `BPP_CLK_MHZ,
	parameter int SC_DET = `BPP_SC_DET_US * `BPP_CLK_MHZ
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Comparator flags and delay shortening select
	input wire logic ovchg_cmp,
	input wire logic ovchg_rel_cmp,
	input wire logic ovdis_cmp,
	input wire logic ovcur_cmp,
	input wire logic short_cmp,
	input wire logic xchg_cmp,
	input wire logic charger_cmp,
	input wire logic shorten_sel,
	// Outputs
	output logic chg_on,
	output logic dis_on,
	output bpp_pkg::bpp_vm_t vm_mode,
	output logic standby
);
	import bpp_pkg::*;

	// Two-flop synchronisers for every comparator flag
	localparam int NF = 8;
	logic [NF-1:0] s1_r;
	logic [NF-1:0] s2_r;
	wire [NF-1:0] raw = {shorten_sel, charger_cmp, xchg_cmp, short_cmp, ovcur_cmp, ovdis_cmp,
		ovchg_rel_cmp, ovchg_cmp};
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
		end
	end
	wire oc_c = s2_r[0];
	wire oc_rel_c = s2_r[1];
	wire od_c = s2_r[2];
	wire oi_c = s2_r[3];
	wire sc_c = s2_r[4];
	wire xc_c = s2_r[5];
	wire chgr_c = s2_r[6];
	wire sh = s2_r[7];

	// Fault states
	logic oc_r;
	logic od_r;
	logic oi_r;
	logic sc_r;
	logic xc_r;
	logic od_after_oc_r;

	// Delay limits, shortened when selected except short circuit
	function automatic logic [CW-1:0] lim(input int n, input logic s);
		int v;
		v = s ? n / `BPP_SHORT_DIV : n;
		if (v < 1) v = 1;
		return CW'(v);
	endfunction

	// Run conditions
	wire oi_block = oc_r | od_r;
	wire oc_det_run = !oc_r && oc_c;
	wire oc_rel_run = oc_r && !oc_rel_c;
	wire od_det_run = !od_r && od_c && !oc_det_run;
	wire od_rel_run = od_r && !od_c && chgr_c;
	wire oi_det_run = !oi_r && !sc_r && oi_c && !oi_block;
	wire fault_rel_run = (oi_r | sc_r) && !oi_c;
	wire sc_det_run = !sc_r && sc_c;
	wire xc_inhibit = od_r | oi_r | sc_r | !dis_on;
	wire xc_det_run = !xc_r && xc_c && !xc_inhibit;
	wire xc_rel_run = xc_r && !xc_c;

	wire oc_det_d;
	wire oc_rel_d;
	wire od_det_d;
	wire od_rel_d;
	wire oi_det_d;
	wire fr_d;
	wire sc_det_d;
	wire xc_det_d;
	wire xc_rel_d;

	// Counter-based delays for each transition except over-current cleared by over-discharge
	bpp_delay #(.CW(CW)) u_oc_det (.clk(clk), .rst(rst), .run(oc_det_run),
		.limit(lim(OC_DET, sh)), .done(oc_det_d));
	bpp_delay #(.CW(CW)) u_oc_rel (.clk(clk), .rst(rst), .run(oc_rel_run),
		.limit(lim(OC_REL, sh)), .done(oc_rel_d));
	bpp_delay #(.CW(CW)) u_od_det (.clk(clk), .rst(rst), .run(od_det_run),
		.limit(lim(OD_DET, sh)), .done(od_det_d));
	bpp_delay #(.CW(CW)) u_od_rel (.clk(clk), .rst(rst), .run(od_rel_run),
		.limit(lim(OD_REL, sh)), .done(od_rel_d));
	bpp_delay #(.CW(CW)) u_oi_det (.clk(clk), .rst(rst), .run(oi_det_run),
		.limit(lim(OI_DET, sh)), .done(oi_det_d));
	bpp_delay #(.CW(CW)) u_fr (.clk(clk), .rst(rst), .run(fault_rel_run),
		.limit(lim(OI_REL, sh)), .done(fr_d));
	bpp_delay #(.CW(CW)) u_sc_det (.clk(clk), .rst(rst), .run(sc_det_run),
		.limit(lim(SC_DET, 1'b0)), .done(sc_det_d));
	bpp_delay #(.CW(CW)) u_xc_det (.clk(clk), .rst(rst), .run(xc_det_run),
		.limit(lim(XC_DET, sh)), .done(xc_det_d));
	bpp_delay #(.CW(CW)) u_xc_rel (.clk(clk), .rst(rst), .run(xc_rel_run),
		.limit(lim(XC_REL, sh)), .done(xc_rel_d));

	// Fault state registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			oc_r <= 1'b0;
			od_r <= 1'b0;
			oi_r <= 1'b0;
			sc_r <= 1'b0;
			xc_r <= 1'b0;
			od_after_oc_r <= 1'b0;
		end else begin
			if (oc_det_d && oc_det_run) oc_r <= 1'b1;
			else if (oc_rel_d && oc_rel_run) oc_r <= 1'b0;
			if (od_det_d && od_det_run) begin
				od_r <= 1'b1;
				od_after_oc_r <= oc_r;
			end else if (od_rel_d && od_rel_run) begin
				od_r <= 1'b0;
				od_after_oc_r <= 1'b0;
			end
			if (oi_det_d && oi_det_run) oi_r <= 1'b1;
			else if (fr_d && fault_rel_run) oi_r <= 1'b0;
			else if (od_r) oi_r <= 1'b0;
			if (sc_det_d && sc_det_run) sc_r <= 1'b1;
			else if (fr_d && fault_rel_run) sc_r <= 1'b0;
			if (xc_det_d && xc_det_run) xc_r <= 1'b1;
			else if (xc_rel_d && xc_rel_run) xc_r <= 1'b0;
		end
	end

	// Sense node and standby decode; stronger state decides the pull
	wire stby_nxt = od_r && !od_after_oc_r && !oc_r;
	bpp_vm_t vm_nxt;
	assign vm_nxt = od_r ? BPP_VM_PULL_UP :
		(oi_r | sc_r) ? BPP_VM_PULL_DOWN :
		BPP_VM_OPEN;
	wire chg_nxt = !(oc_r | xc_r);
	wire dis_nxt = !(od_r | oi_r | sc_r);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chg_on <= 1'b1;
			dis_on <= 1'b1;
			vm_mode <= BPP_VM_OPEN;
			standby <= 1'b0;
		end else begin
			chg_on <= chg_nxt;
			dis_on <= dis_nxt;
			vm_mode <= vm_nxt;
			standby <= stby_nxt;
		end
	end

	property p_oc_blocks_oi;
		@(posedge clk) disable iff (rst) oc_r && !oi_r |=> !oi_r;
	endproperty
	a_oc_blocks_oi: assert property (p_oc_blocks_oi) else $error("over-current set during over-charge");

	property p_od_blocks_oi;
		@(posedge clk) disable iff (rst) od_r |=> !oi_r;
	endproperty
	a_od_blocks_oi: assert property (p_od_blocks_oi) else $error("over-current kept during over-discharge");

	property p_od_pullup;
		@(posedge clk) disable iff (rst) od_r |=> vm_mode == BPP_VM_PULL_UP;
	endproperty
	a_od_pullup: assert property (p_od_pullup) else $error("no pull-up in over-discharge");

	property p_stby_not_after_oc;
		@(posedge clk) disable iff (rst) od_after_oc_r |=> !standby;
	endproperty
	a_stby_not_after_oc: assert property (p_stby_not_after_oc) else $error("standby after over-charge");

	property p_oi_pulldown;
		@(posedge clk) disable iff (rst) (oi_r && !od_r) |=> vm_mode == BPP_VM_PULL_DOWN;
	endproperty
	a_oi_pulldown: assert property (p_oi_pulldown) else $error("no pull-down in over-current");

	property p_oc_open;
		@(posedge clk) disable iff (rst) (oc_r && !od_r && !oi_r && !sc_r) |=> vm_mode == BPP_VM_OPEN;
	endproperty
	a_oc_open: assert property (p_oc_open) else $error("node not released in over-charge");

	property p_xc_inhibit;
		@(posedge clk) disable iff (rst) (od_r | oi_r | sc_r) && !xc_r |=> !xc_r;
	endproperty
	a_xc_inhibit: assert property (p_xc_inhibit) else $error("excessive charger during fault");

	property p_dis_low;
		@(posedge clk) disable iff (rst) (od_r | oi_r | sc_r) |=> !dis_on;
	endproperty
	a_dis_low: assert property (p_dis_low) else $error("discharge output high in fault");

	property p_sc_indep;
		@(posedge clk) disable iff (rst) sc_det_run && sc_det_d |=> sc_r;
	endproperty
	a_sc_indep: assert property (p_sc_indep) else $error("short circuit not latched");

	property p_sc_free;
		@(posedge clk) disable iff (rst) sc_c && !sc_r |-> sc_det_run;
	endproperty
	a_sc_free: assert property (p_sc_free) else $error("short circuit detection suppressed");

	property p_oc_hold_od;
		@(posedge clk) disable iff (rst) oc_det_run && !od_r |=> !od_r;
	endproperty
	a_oc_hold_od: assert property (p_oc_hold_od) else $error("over-discharge set during over-charge count");

	// Over-charge already latched and the cell still low
	sequence s_od_pending;
		oc_r && od_c && !od_r;
	endsequence
	property p_od_resume;
		@(posedge clk) disable iff (rst) s_od_pending |-> od_det_run;
	endproperty
	a_od_resume: assert property (p_od_resume) else $error("over-discharge count not resumed");

	property p_oc_after_oi;
		@(posedge clk) disable iff (rst) oi_r && !oc_r && oc_c |-> oc_det_run;
	endproperty
	a_oc_after_oi: assert property (p_oc_after_oi) else $error("over-charge count stopped by over-current");

	property p_od_stops_oi;
		@(posedge clk) disable iff (rst) od_r |-> !oi_det_run;
	endproperty
	a_od_stops_oi: assert property (p_od_stops_oi) else $error("over-current count during over-discharge");

	// Over-current latched first, then over-discharge latches
	sequence s_od_after_oi;
		oi_r && !od_r && !oc_r ##1 od_r && !oc_r;
	endsequence
	property p_od_after_oi;
		@(posedge clk) disable iff (rst) s_od_after_oi |=> vm_mode == BPP_VM_PULL_UP && standby;
	endproperty
	a_od_after_oi: assert property (p_od_after_oi) else $error("no pull-up or standby after over-current");

	property p_od_standby;
		@(posedge clk) disable iff (rst) od_r && !od_after_oc_r && !oc_r |=> standby;
	endproperty
	a_od_standby: assert property (p_od_standby) else $error("no standby in over-discharge");

	property p_xc_wait_dis;
		@(posedge clk) disable iff (rst) !dis_on && !xc_r |=> !xc_r;
	endproperty
	a_xc_wait_dis: assert property (p_xc_wait_dis) else $error("excessive charger set while discharge low");

	property p_od_counted;
		@(posedge clk) disable iff (rst) $rose(od_r) |-> $past(od_det_d);
	endproperty
	a_od_counted: assert property (p_od_counted) else $error("over-discharge set without delay");

	property p_oi_counted;
		@(posedge clk) disable iff (rst) $rose(oi_r) |-> $past(oi_det_d);
	endproperty
	a_oi_counted: assert property (p_oi_counted) else $error("over-current set without delay");

	property p_od_run_before_done;
		@(posedge clk) disable iff (rst) $rose(od_det_d) |-> $past(od_det_run, 2);
	endproperty
	a_od_run_before_done: assert property (p_od_run_before_done) else $error("delay done without count");

	property p_oi_release;
		@(posedge clk) disable iff (rst) $fell(oi_r) |-> $past(fr_d) || $past(od_r);
	endproperty
	a_oi_release: assert property (p_oi_release) else $error("over-current left without release delay");

	property p_dis_back;
		@(posedge clk) disable iff (rst) $fell(oi_r) && !sc_r && !od_r |=> dis_on;
	endproperty
	a_dis_back: assert property (p_dis_back) else $error("discharge output not restored");

	// A dropped condition must clear the count before it can complete
	property p_od_restart;
		@(posedge clk) disable iff (rst) !od_det_run |=> !od_det_d;
	endproperty
	a_od_restart: assert property (p_od_restart) else $error("delay kept after dropout");
endmodule

// >>> design/bpp_defines.svh
`ifndef BPP_DEFINES_SVH
`define BPP_DEFINES_SVH
// Clock in MHz, then normal delay times in microseconds
`define BPP_CLK_MHZ 40
`define BPP_OC_DET_US 1000
`define BPP_OC_REL_US 1000
`define BPP_OD_DET_US 1000
`define BPP_OD_REL_US 1000
`define BPP_OI_DET_US 1000
`define BPP_OI_REL_US 1000
`define BPP_XC_DET_US 1000
`define BPP_XC_REL_US 1000
`define BPP_SC_DET_US 1
// Shortened delay is normal delay divided by this
`define BPP_SHORT_DIV 16
// Delay counter width
`define BPP_CNT_W 20
`endif

// >>> design/bpp_pkg.sv
package bpp_pkg;
	typedef enum logic [1:0] {
		BPP_VM_OPEN,
		BPP_VM_PULL_DOWN,
		BPP_VM_PULL_UP
	} bpp_vm_t;
endpackage

// >>> design/bpp_delay.sv
`timescale 1ns/1ps
module bpp_delay #(
	parameter int CW = 20
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic run,
	input wire logic [CW-1:0] limit,
	// Result
	output logic done
);
	logic [CW-1:0] cnt_r;
	// Restart whenever the condition drops before the count ends
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
			done <= 1'b0;
		end else if (!run) begin
			cnt_r <= '0;
			done <= 1'b0;
		end else if (cnt_r >= limit) begin
			done <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end
endmodule

// >>> tb/bpp_pack_model.sv
`timescale 1ns/1ps
module bpp_pack_model (
	// Pack conditions set by the bench
	input wire logic cell_hi,
	input wire logic cell_lo,
	input wire logic load_hi,
	input wire logic load_short,
	input wire logic chg_conn,
	input wire logic chg_excess,
	// Comparator flags
	output logic ovchg_cmp,
	output logic ovchg_rel_cmp,
	output logic ovdis_cmp,
	output logic ovcur_cmp,
	output logic short_cmp,
	output logic xchg_cmp,
	output logic charger_cmp
);
	assign ovchg_cmp = cell_hi;
	// Release level kept with the detect level, so a cell is either high or back in range
	assign ovchg_rel_cmp = cell_hi;
	assign ovdis_cmp = cell_lo;
	// A short also lifts the sense node above the over-current level
	assign ovcur_cmp = load_hi | load_short;
	assign short_cmp = load_short;
	assign xchg_cmp = chg_excess;
	assign charger_cmp = chg_conn;
endmodule

// >>> tb/test_protection_detection_priority.sv
`timescale 1ns/1ps
`define CHK(a, e, m) begin checks_done++; if (((a) & (m)) !== ((e) & (m))) begin fail_count++; \
	$display("Error at %0t: got %h expected %h", $time, (a) & (m), (e) & (m)); end end
module test_protection_detection_priority;
	import bpp_pkg::*;
	localparam logic [4:0] ALL = 5'h1F;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cell_hi = 1'b0, cell_lo = 1'b0, load_hi = 1'b0, load_short = 1'b0, chg_conn = 1'b0, chg_excess = 1'b0;
	logic shorten = 1'b0;
	logic ovchg_cmp, ovchg_rel_cmp, ovdis_cmp, ovcur_cmp, short_cmp, xchg_cmp, charger_cmp;
	logic chg_on, dis_on, standby;
	bpp_vm_t vm_mode;
	logic [4:0] outs;
	logic [9:0] notes[$];
	event sample_ev;
	int fail_count = 0;
	int checks_done = 0;
	logic [31:0] lfsr_r = 32'h1C40;
	assign outs = {chg_on, dis_on, vm_mode, standby};
	initial begin
		forever #12.5 clk = ~clk;
	end
	bpp_pack_model pack (.cell_hi(cell_hi), .cell_lo(cell_lo), .load_hi(load_hi), .load_short(load_short),
		.chg_conn(chg_conn), .chg_excess(chg_excess), .ovchg_cmp(ovchg_cmp), .ovchg_rel_cmp(ovchg_rel_cmp),
		.ovdis_cmp(ovdis_cmp), .ovcur_cmp(ovcur_cmp), .short_cmp(short_cmp), .xchg_cmp(xchg_cmp),
		.charger_cmp(charger_cmp));
	// Only delays the scenarios wait on are cut to 20; short circuit keeps its 40-cycle default
	bpp_top #(.OC_DET(20), .OD_DET(20), .OI_DET(20), .OI_REL(20), .XC_DET(20)) dut (.clk(clk), .rst(rst),
		.ovchg_cmp(ovchg_cmp), .ovchg_rel_cmp(ovchg_rel_cmp), .ovdis_cmp(ovdis_cmp), .ovcur_cmp(ovcur_cmp),
		.short_cmp(short_cmp), .xchg_cmp(xchg_cmp), .charger_cmp(charger_cmp), .shorten_sel(shorten),
		.chg_on(chg_on), .dis_on(dis_on), .vm_mode(vm_mode), .standby(standby));
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic note(input logic [4:0] m, input logic [4:0] v);
		notes.push_back({m, v});
		-> sample_ev;
	endtask
	task automatic restart;
		rst = 1'b1;
		{cell_hi, cell_lo, load_hi, load_short, chg_conn, chg_excess} = 6'h00;
		shorten = 1'b0;
		tick(8);
		rst = 1'b0;
	endtask
	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		logic [9:0] n;
		forever begin
			@(sample_ev);
			n = notes.pop_front();
			`CHK(outs, n[4:0], n[9:5])
		end
	end
	initial begin
		tick(4000);
		fail_count++;
		give_verdict();
	end
	initial begin
		restart();
		cell_lo = 1'b1;
		tick(15);
		note(ALL, {1'b1, 1'b1, BPP_VM_OPEN, 1'b0});
		tick(15);
		note(ALL, {1'b1, 1'b0, BPP_VM_PULL_UP, 1'b1});
		restart();
		{cell_hi, cell_lo} = 2'h3;
		tick(30);
		note(ALL, {1'b0, 1'b1, BPP_VM_OPEN, 1'b0});
		tick(30);
		note(ALL, {1'b0, 1'b0, BPP_VM_PULL_UP, 1'b0});
		restart();
		load_hi = 1'b1;
		tick(30);
		note(ALL, {1'b1, 1'b0, BPP_VM_PULL_DOWN, 1'b0});
		cell_hi = 1'b1;
		tick(30);
		note(ALL, {1'b0, 1'b0, BPP_VM_PULL_DOWN, 1'b0});
		restart();
		load_hi = 1'b1;
		tick(30);
		cell_lo = 1'b1;
		tick(30);
		note(ALL, {1'b1, 1'b0, BPP_VM_PULL_UP, 1'b1});
		restart();
		cell_lo = 1'b1;
		tick(30);
		load_hi = 1'b1;
		tick(30);
		note(ALL, {1'b1, 1'b0, BPP_VM_PULL_UP, 1'b1});
		restart();
		cell_hi = 1'b1;
		tick(30);
		load_hi = 1'b1;
		tick(30);
		note(ALL, {1'b0, 1'b1, BPP_VM_OPEN, 1'b0});
		load_short = 1'b1;
		tick(50);
		note(5'h08, 5'h00);
		restart();
		load_hi = 1'b1;
		tick(30);
		chg_excess = 1'b1;
		tick(30);
		note(ALL, {1'b1, 1'b0, BPP_VM_PULL_DOWN, 1'b0});
		load_hi = 1'b0;
		tick(32);
		note(5'h18, 5'h18);
		tick(30);
		note(5'h18, 5'h08);
		restart();
		{shorten, cell_lo} = 2'h3;
		tick(10);
		note(ALL, {1'b1, 1'b0, BPP_VM_PULL_UP, 1'b1});
		restart();
		repeat (20) begin
			cell_lo = 1'b1;
			tick(int'(lfsr_r[3:0]) % 12 + 1);
			cell_lo = 1'b0;
			tick(3);
			lfsr_r = lfsr_next(lfsr_r);
		end
		tick(30);
		note(ALL, {1'b1, 1'b1, BPP_VM_OPEN, 1'b0});
		tick(1);
		give_verdict();
	end
endmodule
